// [rtl/adcsp_pkg.sv]
package adcsp_pkg;

  // ----------------------------------------------------------------
  // Command byte layout
  // ----------------------------------------------------------------
  localparam int CMD_W     = 8;
  localparam int CH_MSB    = 6;
  localparam int CH_LSB    = 4;
  localparam int SGL_POS   = 3;
  localparam int UNI_POS   = 2;
  localparam int PD_HI_POS = 1;
  localparam int PD_LO_POS = 0;

  // ----------------------------------------------------------------
  // Link timing, counted in serial clock edges
  // ----------------------------------------------------------------
  localparam int              RES_W          = 14;
  localparam logic [5:0]      FCNT_MAX       = 6'h3f;
  localparam logic [5:0]      ONE6           = 6'h01;
  localparam logic [3:0]      CMD_LAST_BIT   = 4'h7;
  localparam logic [3:0]      ONE4           = 4'h1;
  localparam logic [5:0]      STRB_RISE_FALL = 6'h10;
  localparam logic [5:0]      EXT_DONE_FALL  = 6'h12;
  localparam logic [4:0]      RES_LAST       = 5'h0d;
  localparam logic [4:0]      ONE5           = 5'h01;

  // ----------------------------------------------------------------
  // Core timing: internal conversion length
  // ----------------------------------------------------------------
  localparam int         CORE_CLK_MHZ = 100;
  localparam int         CONV_TIME_NS = 7500;
  localparam int         CONV_CYC     =
    (CONV_TIME_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam logic [9:0] CONV_LOAD    = 10'(CONV_CYC - 1);
  localparam logic [9:0] ONE10        = 10'h001;
  localparam int         FIFO_DEPTH   = 16;

  // ----------------------------------------------------------------
  // Synchroniser bit positions in the core domain
  // ----------------------------------------------------------------
  localparam int CS_BIT   = 4;
  localparam int SHUTDOWN_N_INPUT_BIT = 3;
  localparam int CMD_BIT  = 2;
  localparam int ACK_BIT  = 1;
  localparam int EXTS_BIT = 0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ADCSP_FULL_PD = 2'b00,
    ADCSP_FAST_PD = 2'b01,
    ADCSP_INT_CLK = 2'b10,
    ADCSP_EXT_CLK = 2'b11
  } adcsp_mode_t;

  typedef enum logic [1:0] {
    ADCSP_PWR_ACTIVE = 2'b00,
    ADCSP_PWR_FAST   = 2'b01,
    ADCSP_PWR_FULL   = 2'b10,
    ADCSP_PWR_SHUTDOWN_N_INPUT   = 2'b11
  } adcsp_pwr_t;

  typedef enum logic [1:0] {
    ADCSP_RX_IDLE = 2'b00,
    ADCSP_RX_CMD  = 2'b01,
    ADCSP_RX_BUSY = 2'b10
  } adcsp_rx_t;

  typedef enum logic [0:0] {
    ADCSP_CV_IDLE = 1'b0,
    ADCSP_CV_RUN  = 1'b1
  } adcsp_cv_t;

  typedef struct packed {
    logic [2:0]  channel_select;
    logic        single_diff_select;
    logic        polarity_select;
    adcsp_mode_t mode;
  } adcsp_cfg_t;

  localparam adcsp_cfg_t CFG_RST = '{3'h0, 1'b0, 1'b0, ADCSP_FULL_PD};

endpackage

// [rtl/adcsp_fifo.sv]
`timescale 1ns/1ns
module adcsp_fifo
  import adcsp_pkg::*;
#(
  parameter int W     = 14,
  parameter int DEPTH = 16
)(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic      [W-1:0] out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW:0] CNT_ONE  = (AW + 1)'(1);
  localparam logic [AW-1:0] PTR_ONE = AW'(1);

  logic [W-1:0]  mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0]   count_ff;
  logic          ready_ff;
  logic [AW:0]   nxt_count;
  logic          push;
  logic          pop;

  // ----------------------------------------------------------------
  // Handshake decode
  // ----------------------------------------------------------------
  assign push      = in_valid && ready_ff;
  assign pop       = out_ready && (count_ff != '0);
  assign out_valid = (count_ff != '0);
  assign out_data  = mem_ff[rd_ptr_ff];
  assign in_ready  = ready_ff;
  assign nxt_count = count_ff + (push ? CNT_ONE : '0) - (pop ? CNT_ONE : '0);

  // Storage array, no reset needed on data
  always_ff @(posedge clk)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data;
  end

  // Pointers and fill level; ready is registered so it is honest full
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
      ready_ff  <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + PTR_ONE;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + PTR_ONE;
      count_ff <= nxt_count;
      ready_ff <= (nxt_count != FULL_CNT);
    end
  end

endmodule

// [rtl/adcsp_port.sv]
`timescale 1ns/1ns
module adcsp_port
  import adcsp_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             sclk,
  input  wire logic             cs_n,
  input  wire logic             din,
  output logic                  dout,
  output logic                  dout_oe_n,
  output logic                  conversion_strobe,
  output logic                  strobe_oe_n,
  input  wire logic             shutdown_n_input,
  input  wire logic [RES_W-1:0] smp_data,
  input  wire logic             smp_valid,
  output logic                  smp_ready,
  output adcsp_cfg_t            cfg_out,
  output logic                  cfg_stb,
  output adcsp_pwr_t            pwr_state
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  adcsp_rx_t        rx_state_ff;
  logic [3:0]       bit_cnt_ff;
  logic [6:0]       rx_shift_ff;
  adcsp_cfg_t       cmd_ff;
  logic             cmd_tgl_ff;
  logic [2:0]       l_s1_ff;
  logic [2:0]       l_s2_ff;
  logic [5:0]       fcnt_ff;
  logic [RES_W-1:0] tx_shift_ff;
  logic [4:0]       tx_left_ff;
  logic             loaded_ff;
  logic             dout_ff;
  logic             dout_oe_n_ff;
  logic             ext_strb_ff;
  logic             res_ack_ff;
  logic [4:0]       c_s1_ff;
  logic [4:0]       c_s2_ff;
  logic             c_cmd_d_ff;
  adcsp_cv_t        cv_state_ff;
  logic [9:0]       conv_cnt_ff;
  logic             strobe_ff;
  logic             strobe_oe_n_ff;
  adcsp_cfg_t       cfg_ff;
  logic             cfg_stb_ff;
  adcsp_pwr_t       pwr_ff;
  logic [RES_W-1:0] res_word_ff;
  logic             res_req_ff;
  logic [CMD_W-1:0] cmd_byte;
  adcsp_cfg_t       cmd_dec;
  logic             cmd_now;
  logic             start_seen;
  logic             link_rst;
  logic             shutdown_n_input_l;
  logic             res_new;
  logic             ext_l;
  logic             int_l;
  logic [5:0]       nxt_fcnt;
  logic             load_now;
  logic             tx_done;
  logic             cmd_evt;
  logic             shutdown_n_input_c;
  logic             ext_c;
  logic             int_start;
  logic             conv_fin;
  logic             res_free;
  logic             pub_now;
  logic             fifo_valid;
  logic [RES_W-1:0] fifo_data;
  logic             fifo_pop;

  // ----------------------------------------------------------------
  // Link side: command receive on rising serial clock
  // ----------------------------------------------------------------

  // Decode the byte as it completes; bit 7 is the start bit itself
  assign cmd_byte   = {rx_shift_ff, din};
  assign cmd_dec    = '{cmd_byte[CH_MSB:CH_LSB], cmd_byte[SGL_POS],
                        cmd_byte[UNI_POS],
                        adcsp_mode_t'({cmd_byte[PD_HI_POS],
                                       cmd_byte[PD_LO_POS]})};
  assign cmd_now    = (rx_state_ff == ADCSP_RX_CMD)
                      && (bit_cnt_ff == CMD_LAST_BIT);
  assign start_seen = (rx_state_ff == ADCSP_RX_IDLE) && din && shutdown_n_input_l;
  assign link_rst   = l_s2_ff[2];
  assign shutdown_n_input_l     = l_s2_ff[1];
  assign res_new    = l_s2_ff[0] ^ res_ack_ff;
  assign ext_l      = (cmd_ff.mode == ADCSP_EXT_CLK);
  assign int_l      = (cmd_ff.mode == ADCSP_INT_CLK);
  assign tx_done    = loaded_ff && (tx_left_ff == '0);

  // Frame state; chip select high ends the frame even with sclk stopped
  // capture on rise
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      rx_state_ff <= ADCSP_RX_IDLE;
      bit_cnt_ff  <= '0;
      rx_shift_ff <= '0;
    end
    else
    begin
      case (rx_state_ff)
        // leading zeros skipped until the start bit
        ADCSP_RX_IDLE:
        begin
          if (start_seen)
          begin
            rx_state_ff <= ADCSP_RX_CMD;
            rx_shift_ff <= 7'h01;
            bit_cnt_ff  <= ONE4;
          end
        end
        ADCSP_RX_CMD:
        begin
          rx_shift_ff <= cmd_byte[6:0];
          bit_cnt_ff  <= bit_cnt_ff + ONE4;
          if (cmd_now)
            rx_state_ff <= cmd_dec.mode[1] ? ADCSP_RX_BUSY : ADCSP_RX_IDLE;
        end
        ADCSP_RX_BUSY:
        begin
          if (tx_done)
            rx_state_ff <= ADCSP_RX_IDLE;
        end
        default:
          rx_state_ff <= ADCSP_RX_IDLE;
      endcase
    end
  end

  // Command word and its event toggle outlive the frame
  // fields latched as decoded
  always_ff @(posedge sclk)
  begin
    l_s1_ff <= {sys_rst, shutdown_n_input, res_req_ff};
    l_s2_ff <= l_s1_ff;
    if (link_rst)
    begin
      cmd_ff     <= CFG_RST;
      cmd_tgl_ff <= 1'b0;
    end
    else if (cmd_now)
    begin
      cmd_ff     <= cmd_dec;
      cmd_tgl_ff <= ~cmd_tgl_ff;
    end
  end

  // ----------------------------------------------------------------
  // Link side: result transmit on falling serial clock
  // ----------------------------------------------------------------
  assign nxt_fcnt = (fcnt_ff == FCNT_MAX) ? fcnt_ff : fcnt_ff + ONE6;

  // external conversion ends on a counted serial edge
  assign load_now = (rx_state_ff == ADCSP_RX_BUSY) && !loaded_ff
                    && ((ext_l && nxt_fcnt == EXT_DONE_FALL)
                        || (int_l && res_new));

  // all link outputs move only on the falling edge or when chip select goes high
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      // released at once, no sclk edge needed
      dout_oe_n_ff <= 1'b1;
      dout_ff      <= 1'b0;
      fcnt_ff      <= '0;
      tx_shift_ff  <= '0;
      tx_left_ff   <= '0;
      loaded_ff    <= 1'b0;
      ext_strb_ff  <= 1'b0;
    end
    else
    begin
      dout_oe_n_ff <= 1'b0;
      fcnt_ff      <= (rx_state_ff == ADCSP_RX_IDLE) ? '0 : nxt_fcnt;
      // two periods high, dropping as the MSB appears
      if (ext_l && rx_state_ff == ADCSP_RX_BUSY
          && nxt_fcnt == STRB_RISE_FALL)
        ext_strb_ff <= 1'b1;
      else if (nxt_fcnt == EXT_DONE_FALL)
        ext_strb_ff <= 1'b0;
      if (rx_state_ff == ADCSP_RX_IDLE)
        loaded_ff <= 1'b0;
      if (load_now)
      begin
        tx_shift_ff <= res_new ? res_word_ff : '0;
        dout_ff     <= res_new && res_word_ff[RES_W-1];
        tx_left_ff  <= RES_LAST;
        loaded_ff   <= 1'b1;
      end
      else if (tx_left_ff != '0)
      begin
        tx_shift_ff <= {tx_shift_ff[RES_W-2:0], 1'b0};
        dout_ff     <= tx_shift_ff[RES_W-2];
        tx_left_ff  <= tx_left_ff - ONE5;
      end
      else
        dout_ff <= 1'b0;
    end
  end

  // Acknowledge toggle survives frames, so it uses the synced reset
  always_ff @(negedge sclk)
  begin
    if (link_rst)
      res_ack_ff <= 1'b0;
    else if (load_now && res_new)
      res_ack_ff <= ~res_ack_ff;
  end

  // ----------------------------------------------------------------
  // Core side: crossings in, power and conversion control
  // ----------------------------------------------------------------
  assign cmd_evt   = c_s2_ff[CMD_BIT] ^ c_cmd_d_ff;
  assign shutdown_n_input_c    = !c_s2_ff[SHUTDOWN_N_INPUT_BIT];
  assign ext_c     = (cfg_ff.mode == ADCSP_EXT_CLK);
  assign int_start = cmd_evt && !shutdown_n_input_c
                     && (cmd_ff.mode == ADCSP_INT_CLK);
  assign conv_fin  = (cv_state_ff == ADCSP_CV_RUN) && (conv_cnt_ff == '0);
  assign res_free  = (res_req_ff == c_s2_ff[ACK_BIT]);
  assign pub_now   = conv_fin || (cmd_evt && !shutdown_n_input_c
                     && cmd_ff.mode == ADCSP_EXT_CLK);
  assign fifo_pop  = pub_now && res_free && fifo_valid;

  // Two-stage synchronisers; only the second stage is looked at
  always_ff @(posedge core_clk)
  begin
    c_s1_ff <= {cs_n, shutdown_n_input, cmd_tgl_ff, res_ack_ff,
                ext_strb_ff};
    c_s2_ff <= c_s1_ff;
  end

  // Command arrival: config, power state and the strobe pulse
  // shutdown blocks commands and forces the power state
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      c_cmd_d_ff <= 1'b0;
      cfg_ff     <= CFG_RST;
      cfg_stb_ff <= 1'b0;
      pwr_ff     <= ADCSP_PWR_FULL;
    end
    else
    begin
      c_cmd_d_ff <= c_s2_ff[CMD_BIT];
      cfg_stb_ff <= cmd_evt && !shutdown_n_input_c;
      if (shutdown_n_input_c)
        pwr_ff <= ADCSP_PWR_SHUTDOWN_N_INPUT;
      else if (cmd_evt)
      begin
        cfg_ff <= cmd_ff;
        case (cmd_ff.mode)
          ADCSP_FULL_PD: pwr_ff <= ADCSP_PWR_FULL;
          ADCSP_FAST_PD: pwr_ff <= ADCSP_PWR_FAST;
          default:       pwr_ff <= ADCSP_PWR_ACTIVE;
        endcase
      end
      else if (pwr_ff == ADCSP_PWR_SHUTDOWN_N_INPUT)
        pwr_ff <= ADCSP_PWR_ACTIVE;
    end
  end

  // Internal conversion timer, core clock paced
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || shutdown_n_input_c)
    begin
      cv_state_ff <= ADCSP_CV_IDLE;
      conv_cnt_ff <= '0;
    end
    else
    begin
      case (cv_state_ff)
        ADCSP_CV_IDLE:
        begin
          if (int_start)
          begin
            cv_state_ff <= ADCSP_CV_RUN;
            conv_cnt_ff <= CONV_LOAD;
          end
        end
        ADCSP_CV_RUN:
        begin
          if (conv_fin)
            cv_state_ff <= ADCSP_CV_IDLE;
          else
            conv_cnt_ff <= conv_cnt_ff - ONE10;
        end
        default:
          cv_state_ff <= ADCSP_CV_IDLE;
      endcase
    end
  end

  // Strobe pin lives here so internal mode works with sclk stopped
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      strobe_ff      <= 1'b0;
      strobe_oe_n_ff <= 1'b1;
    end
    else
    begin
      // external mode floats the strobe with the frame closed
      strobe_oe_n_ff <= ext_c && c_s2_ff[CS_BIT];
      if (ext_c)
        strobe_ff <= c_s2_ff[EXTS_BIT];
      // low through conversion, high when it finishes
      else if (int_start)
        strobe_ff <= 1'b0;
      else if (conv_fin || shutdown_n_input_c)
        strobe_ff <= 1'b1;
    end
  end

  // Publish one result word; held stable until the link acknowledges
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      res_req_ff  <= 1'b0;
      res_word_ff <= '0;
    end
    else if (pub_now && res_free)
    begin
      res_req_ff  <= ~res_req_ff;
      res_word_ff <= fifo_valid ? fifo_data : '0;
    end
  end

  // ----------------------------------------------------------------
  // Sample buffer; a full buffer stalls the sample source
  // ----------------------------------------------------------------
  adcsp_fifo #(
    .W     (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .rst       (sys_rst),
    .in_data   (smp_data),
    .in_valid  (smp_valid),
    .in_ready  (smp_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // Outputs, each from a flop
  assign dout              = dout_ff;
  assign dout_oe_n         = dout_oe_n_ff;
  assign conversion_strobe = strobe_ff;
  assign strobe_oe_n       = strobe_oe_n_ff;
  assign cfg_out           = cfg_ff;
  assign cfg_stb           = cfg_stb_ff;
  assign pwr_state         = pwr_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  dout_float_a: assert property (
    @(posedge core_clk) disable iff (sys_rst) cs_n |-> dout_oe_n)
    else $error("result pin driven with chip select high");

  dout_edge_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (!cs_n && $changed(dout) && !$past(cs_n)) |-> !sclk)
    else $error("result pin moved outside sclk low phase");

  start_take_a: assert property (
    @(posedge sclk) disable iff (cs_n)
    start_seen |=> (rx_state_ff == ADCSP_RX_CMD) && rx_shift_ff[0])
    else $error("start bit not taken");

  cmd_latch_a: assert property (
    @(posedge sclk) disable iff (cs_n || link_rst)
    cmd_now |=> (cmd_ff == $past(cmd_dec)) && $changed(cmd_tgl_ff))
    else $error("command byte not latched");

  ext_pulse_a: assert property (
    @(negedge sclk) disable iff (cs_n)
    $rose(ext_strb_ff) |=> ext_strb_ff ##1 (!ext_strb_ff && loaded_ff))
    else $error("external strobe not two periods before MSB");

  ext_done_a: assert property (
    @(negedge sclk) disable iff (cs_n)
    (ext_l && fcnt_ff == EXT_DONE_FALL && rx_state_ff == ADCSP_RX_BUSY)
    |-> loaded_ff && (tx_left_ff == RES_LAST))
    else $error("external conversion not done on its edge");

  strobe_float_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (cs_n && ext_c) [*3] |=> strobe_oe_n)
    else $error("external strobe driven with chip select high");

  int_low_a: assert property (
    @(posedge core_clk) disable iff (sys_rst || shutdown_n_input_c)
    int_start && !ext_c |=> !conversion_strobe [*8])
    else $error("internal strobe not low while converting");

  int_high_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    conv_fin && !ext_c |=> conversion_strobe)
    else $error("internal strobe not high after conversion");

  shutdown_n_input_hold_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    shutdown_n_input_c |=> (pwr_state == ADCSP_PWR_SHUTDOWN_N_INPUT) && !cfg_stb)
    else $error("shutdown not honoured");

  mode_dec_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (cmd_evt && !shutdown_n_input_c && cmd_ff.mode == ADCSP_FAST_PD)
    |=> cfg_stb && (pwr_state == ADCSP_PWR_FAST))
    else $error("power mode decode wrong");

endmodule

// [tb/adcsp_host.sv]
`timescale 1ns/1ns
module adcsp_host
  import adcsp_pkg::*;
(
  output logic             sclk,
  output logic             cs_n,
  output logic             din,
  input  wire logic        dout,
  input  wire logic        conversion_strobe,
  output logic [RES_W-1:0] res_word,
  output logic [3:0]       strb4,
  output logic             res_valid
);
  // ------------------------------------------------
  // Host end of the serial link
  // ------------------------------------------------
  // Clock stands still and deselected between frames
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    res_valid = 1'b0;
    res_word = '0;
    strb4 = '0;
  end

  task automatic spin(input int n);
    repeat (n)
    begin
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
  endtask

  task automatic frame(input logic [7:0] cmd, input int lead, input int post);
    logic [31:0] s;
    logic [31:0] st;
    int          k;
    s = '0;
    st = '0;
    cs_n = 1'b0;
    #40;
    for (int i = 0; i < lead + 8 + post; i++)
    begin
      // Internal mode: clock halts until the conversion ends
      if (i == lead + 8 && cmd[1:0] == 2'b10)
      begin
        #200;
        k = 0;
        while (conversion_strobe !== 1'b1 && k < 2000)
        begin
          #10 k++;
        end
      end
      din = (i >= lead && i < lead + 8) ? cmd[lead + 7 - i] : 1'b0;
      #32 sclk = 1'b1;
      s = {s[30:0], dout};
      st = {st[30:0], conversion_strobe};
      #32 sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    din = ~din;
    if (post > 0)
    begin
      res_word = s[RES_W-1:0];
      strb4 = st[16:13];
      res_valid = 1'b1;
      #1 res_valid = 1'b0;
    end
    #100;
  endtask
endmodule

// [tb/adcsp_port_tb_top.sv]
`timescale 1ns/1ns
module adcsp_port_tb_top
  import adcsp_pkg::*;
();
  // ------------------------------------------------
  // Signals, clock, instances
  // ------------------------------------------------
  logic             core_clk;
  logic             sys_rst;
  logic             shutdown_n_input;
  logic             smp_valid;
  logic [RES_W-1:0] smp_data;
  logic             sclk;
  logic             cs_n;
  logic             din;
  logic             dout;
  logic             dout_oe_n;
  logic             conversion_strobe;
  logic             strobe_oe_n;
  logic             smp_ready;
  adcsp_cfg_t       cfg_out;
  logic             cfg_stb;
  adcsp_pwr_t       pwr_state;
  logic [RES_W-1:0] res_word;
  logic [3:0]       strb4;
  logic             res_valid;
  logic [14:0]      res_e;
  int               fail_count;
  int               check_count;
  int               low_c;
  int               low_last;
  adcsp_cfg_t       cfg_q[$];
  logic [14:0]      res_q[$];
  logic [RES_W-1:0] fifo_m[$];
  // Released pins show the inverse of their last value
  wire dout_pin = dout_oe_n ? ~dout : dout;
  wire strb_pin = strobe_oe_n ? ~conversion_strobe : conversion_strobe;

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  adcsp_port adcsp_port_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout(dout), .dout_oe_n(dout_oe_n),
    .conversion_strobe(conversion_strobe), .strobe_oe_n(strobe_oe_n),
    .shutdown_n_input(shutdown_n_input), .smp_data(smp_data),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .cfg_out(cfg_out),
    .cfg_stb(cfg_stb), .pwr_state(pwr_state)
  );
  adcsp_host adcsp_host_i (
    .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_pin),
    .conversion_strobe(strb_pin), .res_word(res_word), .strb4(strb4),
    .res_valid(res_valid)
  );

  // ------------------------------------------------
  // Compare, watchers, drivers
  // ------------------------------------------------
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cfg(input adcsp_cfg_t got, input adcsp_cfg_t exp);
    chk_val(16'(got), 16'(exp));
  endtask

  // Settled values are read on the falling core edge
  always @(negedge core_clk)
    if (cfg_stb === 1'b1)
      chk_cfg(cfg_out, cfg_q.size() ? cfg_q.pop_front() : ~cfg_out);

  // Length of the last low stretch of the strobe
  always @(negedge core_clk)
    if (conversion_strobe === 1'b0)
      low_c++;
    else
    begin
      if (low_c > 0)
        low_last = low_c;
      low_c = 0;
    end

  always @(posedge res_valid)
  begin
    res_e = res_q.size() ? res_q.pop_front() : 15'h3fff;
    chk_val(16'(res_word), 16'(res_e[13:0]));
    if (res_e[14])
      chk_val(16'(strb4), 16'h0006);
  end

  task automatic offer(input logic [RES_W-1:0] w, output bit acc);
    #1 smp_data = w;
    smp_valid = 1'b1;
    acc = (smp_ready === 1'b1);
    @(posedge core_clk);
    if (acc)
      fifo_m.push_back(w);
  endtask

  task automatic push_w();
    bit acc;
    @(posedge core_clk);
    do
      offer(14'($urandom), acc);
    while (!acc);
    #1 smp_valid = 1'b0;
  endtask

  task automatic send(input logic [7:0] cmd);
    int post;
    post = cmd[1] ? (cmd[0] ? 24 : 16) : 0;
    cfg_q.push_back(adcsp_cfg_t'(cmd[6:0]));
    if (post > 0)
      res_q.push_back({cmd[0], fifo_m.size() ? fifo_m.pop_front() : 14'h0});
    adcsp_host_i.frame(cmd, $urandom % 4, post);
    repeat (8) @(posedge core_clk);
    #1 chk_val(16'(dout_oe_n), 16'h0001);
    chk_val(16'(pwr_state), 16'(cmd[1] ? ADCSP_PWR_ACTIVE : cmd[0] ?
      ADCSP_PWR_FAST : ADCSP_PWR_FULL));
    if (cmd[1:0] == 2'b11)
      chk_val(16'(strobe_oe_n), 16'h0001);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial
  begin
    #400000;
    fail_count++;
    close_out();
  end

  // ------------------------------------------------
  // Test sequence
  // ------------------------------------------------
  initial
  begin
    int n;
    int exp_n;
    bit acc;
    sys_rst = 1'b1;
    shutdown_n_input = 1'b1;
    smp_valid = 1'b0;
    smp_data = '0;
    fail_count = 0;
    check_count = 0;
    low_c = 0;
    low_last = 0;
    void'($urandom(32'h458aee14));
    // Link logic needs sclk edges while reset is held
    fork
      adcsp_host_i.spin(3);
      repeat (16) @(posedge core_clk);
    join
    @(posedge core_clk);
    #1 sys_rst = 1'b0;
    adcsp_host_i.spin(3);
    @(posedge core_clk);
    #1 chk_val(16'(dout_oe_n), 16'h0001);
    chk_val(16'(pwr_state), 16'(ADCSP_PWR_FULL));
    chk_val(16'(cfg_out), 16'h0000);
    $display("test reset done");
    // every mode, random fields and lead zeros
    for (int m = 0; m < 8; m++)
    begin
      push_w();
      send({1'b1, 5'($urandom), 2'(m)});
    end
    $display("test modes done");
    // second conversion starts from a high strobe
    repeat (2) send({1'b1, 5'($urandom), 2'b10});
    chk_val(16'(low_last), 16'(CONV_CYC));
    $display("test internal done");
    // Fill until refused, then drain with back-to-back frames
    exp_n = FIFO_DEPTH - fifo_m.size();
    n = 0;
    @(posedge core_clk);
    repeat (20)
    begin
      offer(14'($urandom), acc);
      n += acc;
    end
    #1 smp_valid = 1'b0;
    chk_val(16'(n), 16'(exp_n));
    chk_val(16'(smp_ready), 16'h0000);
    repeat (fifo_m.size() + 1) send({1'b1, 5'($urandom), 2'b11});
    chk_val(16'(smp_ready), 16'h0001);
    $display("test buffer done");
    @(posedge core_clk);
    #1 shutdown_n_input = 1'b0;
    repeat (6) @(posedge core_clk);
    #1 chk_val(16'(pwr_state), 16'(ADCSP_PWR_SHUTDOWN_N_INPUT));
    // Link side sees the pin only through sclk edges, so give it two
    adcsp_host_i.spin(2);
    adcsp_host_i.frame(8'hff, 0, 0);
    @(posedge core_clk);
    #1 chk_val(16'(pwr_state), 16'(ADCSP_PWR_SHUTDOWN_N_INPUT));
    shutdown_n_input = 1'b1;
    repeat (6) @(posedge core_clk);
    #1 chk_val(16'(pwr_state), 16'(ADCSP_PWR_ACTIVE));
    // Same again on release, else an early start bit is refused
    adcsp_host_i.spin(2);
    push_w();
    send(8'hff);
    $display("test shutdown done");
    close_out();
  end
endmodule
